// File: design/pdc_cable_test.sv
// Purpose: cable diagnostic sequencer, tracks a run of the analog engine and holds its result
// Assumes: engine answers with a one-cycle done pulse and a result valid in that cycle
// Notes: a silent engine is reported as a failed test after a timeout
`timescale 1ns/1ps
`default_nettype none
module pdc_cable_test
  import pdc_pkg::*;
#(
  parameter int TIMEOUT_CYC = TEST_TIMEOUT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic eng_done_i,
  input wire pdc_cable_type eng_res_i,
  output logic run_o,
  output logic done_o,
  output pdc_cable_type res_o
);

  localparam int CW = $clog2(TIMEOUT_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(TIMEOUT_CYC - 1);

  typedef enum logic [0:0] {CT_IDLE, CT_RUN} pdc_ct_state_type;

  pdc_ct_state_type state_ff, nxt_state;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic run_ff, nxt_run;
  logic done_ff, nxt_done;
  pdc_cable_type res_ff, nxt_res;

  // ==========================================================
  // sequencer next state
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_run = run_ff;
    nxt_done = 1'b0;
    nxt_res = res_ff;
    case (state_ff)
      CT_IDLE: begin
        if (start_i) begin
          nxt_state = CT_RUN;
          nxt_cnt = '0;
          nxt_run = 1'b1;
        end
      end
      CT_RUN: begin
        if (eng_done_i) begin
          nxt_res = eng_res_i;
          nxt_done = 1'b1;
          nxt_run = 1'b0;
          nxt_state = CT_IDLE;
        end else if (cnt_ff == LAST) begin
          nxt_res = '{short10: 1'b0, outcome: OUT_FAILED, count: 9'h000};
          nxt_done = 1'b1;
          nxt_run = 1'b0;
          nxt_state = CT_IDLE;
        end else begin
          nxt_cnt = cnt_ff + CW'(1);
        end
      end
      default: begin
        nxt_state = CT_IDLE;
        nxt_run = 1'b0;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= CT_IDLE;
      cnt_ff <= '0;
      run_ff <= 1'b0;
      done_ff <= 1'b0;
      res_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      run_ff <= nxt_run;
      done_ff <= nxt_done;
      res_ff <= nxt_res;
    end
  end

  assign run_o = run_ff;
  assign done_o = done_ff;
  assign res_o = res_ff;

endmodule : pdc_cable_test
`default_nettype wire

// File: design/pdc_pkg.sv
// Purpose: shared constants and types for the phy port status and diagnostic block
// Assumes: 8-bit registers on a plain strobe port, 25 MHz clock
// Notes: register offsets are local word indices on that port
package pdc_pkg;

  // ==========================================================
  // register offsets
  localparam logic [3:0] OFS_LINK_STAT = 4'h0;
  localparam logic [3:0] OFS_CABLE_CTRL = 4'h1;
  localparam logic [3:0] OFS_AUX_STAT = 4'h2;
  localparam logic [3:0] OFS_IRQ_STAT = 4'h3;
  localparam logic [3:0] OFS_IRQ_MASK = 4'h4;

  // ==========================================================
  // field positions
  localparam int LS_TXFC = 4;
  localparam int LS_RXFC = 3;
  localparam int LS_SPEED = 2;
  localparam int LS_DUPLEX = 1;
  localparam int CT_SHORT = 7;
  localparam int CT_RES_HI = 6;
  localparam int CT_RES_LO = 5;
  localparam int CT_GO = 4;
  localparam int CT_FORCE = 3;
  localparam int CT_PSAVE = 2;
  localparam int CT_RLOOP = 1;
  localparam int CT_CNT8 = 0;
  localparam int AUX_LINK = 0;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_LINK = 1;

  // ==========================================================
  // reset values and writable masks
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'h0E;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] MASK_WMASK = 8'h03;
  localparam logic [7:0] IRQ_RST = 8'h00;

  // ==========================================================
  // cable test outcome codes
  localparam logic [1:0] OUT_NORMAL = 2'h0;
  localparam logic [1:0] OUT_OPEN = 2'h1;
  localparam logic [1:0] OUT_SHORT = 2'h2;
  localparam logic [1:0] OUT_FAILED = 2'h3;

  // ==========================================================
  // timing
  localparam int CLK_MHZ = 25;
  localparam int TEST_TIMEOUT_US = 100;
  localparam int TEST_TIMEOUT_CYC = TEST_TIMEOUT_US * CLK_MHZ;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic tx_fc;
    logic rx_fc;
    logic speed100;
    logic full_duplex;
    logic link_det;
  } pdc_link_type;

  typedef struct packed {
    logic short10;
    logic [1:0] outcome;
    logic [8:0] count;
  } pdc_cable_type;

endpackage : pdc_pkg

// File: design/pdc_port_regs.sv
// Purpose: per-port status, cable test control and power/loopback controls
// Assumes: link status inputs come resolved from the phy core, synchronous to clk_i
// Notes: read data stands only in the cycle after the read strobe
//
// Operation
// - status bit reads one while transmit flow control is resolved active.
// - status bit reads one while receive flow control is active.
// - speed bit reads one at 100 Mbps, zero at 10 Mbps.
// - duplex bit reads one for full duplex, zero otherwise.
// - short flag set when test finds a short under ten metres.
// - outcome field: 00 normal, 01 open, 10 short, 11 test failed.
// - writing one to go starts a test; bit self-clears when finished.
// - provide bit 8 of fault count; distance about 0.4 m per count.
// - power saving control bit enables power saving when one.
// - remote loopback bit loops receive pair to transmit pair at the medium layers.
`timescale 1ns/1ps
`default_nettype none
module pdc_port_regs
  import pdc_pkg::*;
#(
  parameter int TIMEOUT_CYC = TEST_TIMEOUT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire pdc_link_type link_i,
  input wire logic eng_done_i,
  input wire pdc_cable_type eng_res_i,
  output logic eng_start_o,
  output logic psave_o,
  output logic rloop_o,
  output logic link_pass_o,
  output logic irq_o
);

  // ==========================================================
  // state
  pdc_link_type stat_ff, nxt_stat;
  logic [7:0] ctrl_ff, nxt_ctrl;
  logic [7:0] rdata_ff, nxt_rdata;
  logic [7:0] ist_ff, nxt_ist;
  logic [7:0] mask_ff, nxt_mask;
  logic link_ff, nxt_link;
  logic irq_ff, nxt_irq;
  logic start_ff, nxt_start;
  logic wr_ctrl, rd_irq;
  logic cdt_run, cdt_done;
  pdc_cable_type cres;
  logic [7:0] events;

  assign wr_ctrl = wr_i && (addr_i == OFS_CABLE_CTRL);
  assign rd_irq = rd_i && (addr_i == OFS_IRQ_STAT);

  // ==========================================================
  // cable test sequencer
  pdc_cable_test #(
    .TIMEOUT_CYC(TIMEOUT_CYC)
  ) u_cable_test (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(start_ff),
    .eng_done_i(eng_done_i),
    .eng_res_i(eng_res_i),
    .run_o(cdt_run),
    .done_o(cdt_done),
    .res_o(cres)
  );

  // ==========================================================
  // control register and start request
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_start = 1'b0;
    if (wr_ctrl) begin
      nxt_ctrl = wdata_i & CTRL_WMASK;
      // a go write during a running test is ignored
      nxt_start = wdata_i[CT_GO] && !cdt_run && !start_ff;
    end
  end

  // control registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_ff <= CTRL_RST;
      start_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      start_ff <= nxt_start;
    end
  end

  assign psave_o = ctrl_ff[CT_PSAVE];
  assign rloop_o = ctrl_ff[CT_RLOOP];
  assign eng_start_o = start_ff;

  // ==========================================================
  // link status capture and link pass
  always_comb begin
    nxt_stat = link_i;
    nxt_link = ctrl_ff[CT_FORCE] | link_i.link_det;
  end

  // link registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      stat_ff <= '0;
      link_ff <= 1'b0;
    end else begin
      stat_ff <= nxt_stat;
      link_ff <= nxt_link;
    end
  end

  assign link_pass_o = link_ff;

  // ==========================================================
  // interrupt status, mask and output
  always_comb begin
    events = 8'h00;
    events[IRQ_DONE] = cdt_done;
    events[IRQ_LINK] = nxt_link ^ link_ff;
    // a new event wins over the clear-on-read
    nxt_ist = (rd_irq ? 8'h00 : ist_ff) | events;
    nxt_mask = mask_ff;
    if (wr_i && (addr_i == OFS_IRQ_MASK)) begin
      nxt_mask = wdata_i & MASK_WMASK;
    end
    nxt_irq = |(nxt_ist & nxt_mask);
  end

  // interrupt registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ist_ff <= IRQ_RST;
      mask_ff <= MASK_RST;
      irq_ff <= 1'b0;
    end else begin
      ist_ff <= nxt_ist;
      mask_ff <= nxt_mask;
      irq_ff <= nxt_irq;
    end
  end

  assign irq_o = irq_ff;

  // ==========================================================
  // read data, valid one cycle after the strobe
  always_comb begin
    nxt_rdata = 8'h00;
    if (rd_i) begin
      case (addr_i)
        OFS_LINK_STAT: begin
          nxt_rdata[LS_TXFC] = stat_ff.tx_fc;
          nxt_rdata[LS_RXFC] = stat_ff.rx_fc;
          nxt_rdata[LS_SPEED] = stat_ff.speed100;
          nxt_rdata[LS_DUPLEX] = stat_ff.full_duplex;
        end
        OFS_CABLE_CTRL: begin
          nxt_rdata = ctrl_ff;
          nxt_rdata[CT_SHORT] = cres.short10;
          nxt_rdata[CT_RES_HI:CT_RES_LO] = cres.outcome;
          nxt_rdata[CT_GO] = cdt_run | start_ff;
          nxt_rdata[CT_CNT8] = cres.count[8];
        end
        OFS_AUX_STAT: nxt_rdata[AUX_LINK] = link_ff;
        OFS_IRQ_STAT: nxt_rdata = ist_ff;
        OFS_IRQ_MASK: nxt_rdata = mask_ff;
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  // read data register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata_o = rdata_ff;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  txfc_status_a: assert property ((rd_i && addr_i == OFS_LINK_STAT)
    |=> rdata_o[LS_TXFC] == $past(link_i.tx_fc, 2))
    else $error("tx flow control bit wrong");

  rxfc_status_a: assert property ((rd_i && addr_i == OFS_LINK_STAT)
    |=> rdata_o[LS_RXFC] == $past(link_i.rx_fc, 2))
    else $error("rx flow control bit wrong");

  speed_status_a: assert property ((rd_i && addr_i == OFS_LINK_STAT)
    |=> rdata_o[LS_SPEED] == $past(link_i.speed100, 2))
    else $error("speed bit wrong");

  duplex_status_a: assert property ((rd_i && addr_i == OFS_LINK_STAT)
    |=> rdata_o[LS_DUPLEX] == $past(link_i.full_duplex, 2))
    else $error("duplex bit wrong");

  short_flag_a: assert property ((cdt_run && eng_done_i)
    |=> cres.short10 == $past(eng_res_i.short10))
    else $error("short flag not from engine result");

  outcome_timeout_a: assert property (($fell(cdt_run) && !$past(eng_done_i))
    |-> cres.outcome == OUT_FAILED && !cres.short10 && cres.count == 9'h000)
    else $error("silent engine not reported as failed");

  go_start_a: assert property ((wr_ctrl && wdata_i[CT_GO] && !cdt_run && !start_ff)
    |=> eng_start_o ##1 cdt_run)
    else $error("go write did not start test");

  go_selfclear_a: assert property (cdt_done
    |-> !cdt_run && !eng_start_o)
    else $error("go bit not cleared at end");

  count_msb_a: assert property ((rd_i && addr_i == OFS_CABLE_CTRL)
    |=> rdata_o[CT_CNT8] == $past(cres.count[8]))
    else $error("fault count bit 8 wrong");

  psave_write_a: assert property (wr_ctrl
    |=> psave_o == $past(wdata_i[CT_PSAVE]))
    else $error("power saving bit not written");

  rloop_write_a: assert property (wr_ctrl
    |=> rloop_o == $past(wdata_i[CT_RLOOP]))
    else $error("remote loopback bit not written");

  force_link_a: assert property (ctrl_ff[CT_FORCE] |=> link_pass_o)
    else $error("forced link not passed");

  reserved_zero_a: assert property ((rd_i && addr_i == OFS_LINK_STAT)
    |=> rdata_o[7:5] == 3'h0 && rdata_o[0] == 1'b0)
    else $error("reserved status bits not zero");

  irq_level_a: assert property (irq_o == |(ist_ff & mask_ff))
    else $error("interrupt output disagrees with status and mask");

  // capture of the engine answer, refusal of a second go
  outcome_capture_a: assert property ((cdt_run && eng_done_i)
    |=> cres.outcome == $past(eng_res_i.outcome) && cres.count == $past(eng_res_i.count))
    else $error("outcome or count not taken from engine result");

  start_pulse_a: assert property (eng_start_o |=> !eng_start_o)
    else $error("start request longer than one cycle");

  go_refused_a: assert property ((wr_ctrl && cdt_run) |=> !eng_start_o)
    else $error("go write accepted while test runs");

  go_readback_a: assert property ((rd_i && addr_i == OFS_CABLE_CTRL && cdt_run)
    |=> rdata_o[CT_GO])
    else $error("go bit not reading one while running");

  // control bits and reserved bits
  ctrl_hold_a: assert property (!wr_ctrl |=> ctrl_ff == $past(ctrl_ff))
    else $error("control register changed without a write");

  force_write_a: assert property (wr_ctrl
    |=> ctrl_ff[CT_FORCE] == $past(wdata_i[CT_FORCE]))
    else $error("force link bit not written");

  link_follow_a: assert property (!ctrl_ff[CT_FORCE]
    |=> link_pass_o == $past(link_i.link_det))
    else $error("link pass not following detection");

  ctrl_reserved_a: assert property (wr_ctrl
    |=> ctrl_ff[7:4] == 4'h0 && ctrl_ff[0] == 1'b0)
    else $error("reserved control bits stored");

  mask_reserved_a: assert property ((wr_i && addr_i == OFS_IRQ_MASK)
    |=> mask_ff[7:2] == 6'h00)
    else $error("reserved mask bits stored");

  rdata_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data not zero outside a read");

  // interrupt status set and clear
  done_sets_a: assert property (cdt_done |=> ist_ff[IRQ_DONE])
    else $error("test done not flagged in status");

  read_clears_a: assert property ((rd_irq && !cdt_done && link_pass_o == nxt_link)
    |=> ist_ff == 8'h00)
    else $error("status not cleared by its read");

  masked_quiet_a: assert property ((mask_ff == 8'h00) |-> !irq_o)
    else $error("interrupt raised with all events masked");

  // main scenarios
  refuse_cov_c: cover property (wr_ctrl && wdata_i[CT_GO] && cdt_run);
  done_cov_c: cover property (cdt_run && eng_done_i ##1 cdt_done);
  timeout_cov_c: cover property ($fell(cdt_run) && cres.outcome == OUT_FAILED);
  irq_cov_c: cover property ($rose(irq_o));
  force_cov_c: cover property (ctrl_ff[CT_FORCE] && !link_i.link_det ##1 link_pass_o);

endmodule : pdc_port_regs
`default_nettype wire

// File: dv/pdc_engine_model.sv
// Purpose: behavioural cable diagnostic engine seen by the port register block
// Assumes: start is a one-cycle pulse, answer is a one-cycle done pulse
// Notes: result lines show the inverse of the result outside the done cycle
`timescale 1ns/1ps
`default_nettype none
module pdc_engine_model
  import pdc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic silent_i,
  input wire logic [3:0] delay_i,
  input wire pdc_cable_type res_i,
  output logic done_o,
  output pdc_cable_type res_o
);
  logic busy_ff;
  logic [3:0] cnt_ff;

  // ==========================================================
  // engine run: wait delay cycles, then one done pulse; silent never answers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_ff <= 1'b0;
      cnt_ff <= 4'h0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i && !silent_i) begin
        busy_ff <= 1'b1;
        cnt_ff <= delay_i;
      end else if (busy_ff) begin
        if (cnt_ff == 4'h0) begin
          busy_ff <= 1'b0;
          done_o <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff - 4'h1;
        end
      end
    end
  end

  // result valid only beside done, garbage otherwise
  assign res_o = done_o ? res_i : pdc_cable_type'(~res_i);
endmodule : pdc_engine_model
`default_nettype wire

// File: dv/phy_port_status_diag_control_tb.sv
// Purpose: self-checking bench for the port status and cable test registers
// Assumes: TIMEOUT_CYC shortened to 20 cycles
// Notes: read results are queued by the driver and checked by a monitor
`timescale 1ns/1ps
`default_nettype none
module phy_port_status_diag_control_tb
  import pdc_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  pdc_link_type link_i = '0;
  logic eng_done_i, eng_start_o, psave_o, rloop_o, link_pass_o, irq_o;
  pdc_cable_type eng_res_i;
  logic silent = 1'b0;
  logic [3:0] delay = 4'h8;
  pdc_cable_type res = '0;
  logic [7:0] rnd = 8'h46;
  logic [7:0] exp_q[$];
  logic rd_d = 1'b0;
  logic [3:0] prev = 4'h0;
  int bad_count = 0;
  int n_tests = 0;
  int n_start = 0;

  always #20 clk_i = ~clk_i;

  pdc_port_regs #(.TIMEOUT_CYC(20)) dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .link_i(link_i), .eng_done_i(eng_done_i),
    .eng_res_i(eng_res_i), .eng_start_o(eng_start_o), .psave_o(psave_o), .rloop_o(rloop_o),
    .link_pass_o(link_pass_o), .irq_o(irq_o));

  pdc_engine_model eng (.clk_i(clk_i), .rst_i(rst_i), .start_i(eng_start_o), .silent_i(silent),
    .delay_i(delay), .res_i(res), .done_o(eng_done_i), .res_o(eng_res_i));

  // ==========================================================
  // helpers
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    exp_q.push_back(exp);
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask : rd

  // bounded wait on irq_o or on the engine done pulse
  task automatic wait_for(input bit on_done, input int lim);
    int k;
    k = 0;
    while (((on_done ? eng_done_i : irq_o) !== 1'b1) && k < lim) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= lim) begin
      bad_count++;
      stop_test();
    end
  endtask : wait_for

  // one cable test with outcome o, expected readback while running and after
  task automatic run_test(input logic [1:0] o, input bit masked);
    rnd = lfsr(rnd);
    res <= '{short10: rnd[7], outcome: o, count: {rnd[6], rnd}};
    delay <= 4'h8 | {1'b0, rnd[2:0]};
    wr(OFS_CABLE_CTRL, 8'h14);
    rd(OFS_CABLE_CTRL, {prev[3:1], 1'b1, 3'h2, prev[0]});
    wr(OFS_CABLE_CTRL, 8'h14);
    wait_for(masked, 200);
    cyc(4);
    // short flag, outcome and count bit 8 of this test; a silent engine gives failed
    prev = silent ? 4'h6 : {rnd[7], o, rnd[6]};
    check({7'h0, irq_o}, {7'h0, !masked});
    rd(OFS_CABLE_CTRL, {prev[3:1], 1'b0, 3'h2, prev[0]});
    rd(OFS_IRQ_STAT, 8'h01);
  endtask : run_test

  // ==========================================================
  // read monitor: oldest queued note against the data in the cycle after rd_i
  // samples at the falling edge, where registered outputs have settled
  always @(negedge clk_i) begin
    if (rd_d) begin
      check(rdata_o, exp_q.pop_front());
    end else begin
      check(rdata_o, 8'h00);
    end
    rd_d <= rd_i;
    if (eng_start_o === 1'b1) n_start++;
  end

  // ==========================================================
  // hang guard
  initial begin
    cyc(20000);
    bad_count++;
    stop_test();
  end

  // ==========================================================
  // main sequence
  initial begin
    cyc(4);
    rst_i <= 1'b0;
    for (int a = 0; a < 16; a += 3) rd(a[3:0], 8'h00);
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      link_i <= {rnd[3:0], 1'b0};
      cyc(3);
      rd(OFS_LINK_STAT, {3'h0, rnd[3:0], 1'b0});
    end
    wr(OFS_IRQ_MASK, 8'hFF);
    rd(OFS_IRQ_MASK, 8'h03);
    wr(OFS_CABLE_CTRL, 8'hEF);
    rd(OFS_CABLE_CTRL, 8'h0E);
    check({5'h0, psave_o, rloop_o, link_pass_o}, 8'h07);
    check({7'h0, irq_o}, 8'h01);
    rd(OFS_IRQ_STAT, 8'h02);
    rd(OFS_AUX_STAT, 8'h01);
    cyc(2);
    check({7'h0, irq_o}, 8'h00);
    link_i <= 5'h01;
    wr(OFS_CABLE_CTRL, 8'h00);
    cyc(3);
    check({5'h0, psave_o, rloop_o, link_pass_o}, 8'h01);
    rd(OFS_AUX_STAT, 8'h01);
    rd(OFS_IRQ_STAT, 8'h00);
    for (int o = 0; o < 4; o++) run_test(o[1:0], 1'b0);
    silent <= 1'b1;
    run_test(2'h0, 1'b0);
    silent <= 1'b0;
    wr(OFS_IRQ_MASK, 8'h00);
    run_test(2'h2, 1'b1);
    check(n_start[7:0], 8'h06);
    cyc(3);
    stop_test();
  end
endmodule : phy_port_status_diag_control_tb
`default_nettype wire
